// ===== bench/idas_bus_peer.sv
// Far side of the serial bus: clocks bytes and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module idas_bus_peer (
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Address MSB first, then direction bit, then ack; 125 ns per clock
   task automatic clock_byte(input logic [8:0] bits);
      #1;
      for (int i = 8; i >= 0; i--) begin
         scl = 1'b0;
         #31;
         sda_low = ~bits[i];
         #31.6;
         scl = 1'b1;
         #62.4;
      end
      scl = 1'b0;
      #31;
      sda_low = 1'b0;
   endtask
   // Clock stands high outside frames
   task automatic release_bus();
      #31;
      scl = 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== bench/idas_status_props.sv
// Checker of the direction, acknowledge and data pin driver behaviour
`timescale 1ns/1ps
`default_nettype none
module idas_status_props
   import idas_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic pready,
   input wire logic serial_data_pin_in,
   input wire logic serial_data_pin_out,
   input wire logic serial_data_pin_oe,
   input wire logic shift_out_latch,
   input wire logic start_generated,
   input wire logic start_detected,
   input wire logic stop_detected,
   input wire logic arbitration_lost,
   input wire logic interface_enable,
   input wire logic direction_flag,
   input wire logic ack_detected_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire ctl_wr = psel && penable && pready && pwrite && paddr == CTRL_OFF;

   a_rx_released: assert property (!direction_flag |->
      !serial_data_pin_oe) else $error("data pin driven while receiving");
   a_tx_latch: assert property (serial_data_pin_oe |->
      serial_data_pin_out == $past(shift_out_latch))
      else $error("driven value is not the latch");
   a_stop_clears: assert property (stop_detected |=>
      !direction_flag && !ack_detected_flag) else $error("stop kept flags");
   a_arb_clears: assert property (arbitration_lost |=>
      !direction_flag) else $error("arbitration loss kept direction");
   a_off_holds: assert property (!interface_enable &&
      !$past(interface_enable) |-> !direction_flag && !ack_detected_flag)
      else $error("flags set while disabled");
   a_exit_clears: assert property (ctl_wr &&
      pwdata[CTRL_EXIT_BIT] |=> !direction_flag && !ack_detected_flag)
      else $error("exit request kept flags");
   a_cancel_release: assert property (ctl_wr &&
      pwdata[CTRL_WAIT_CANCEL_BIT] |=> !direction_flag ##1
      !serial_data_pin_oe) else $error("wait cancel kept driver");
   a_enable_bit: assert property (ctl_wr |=>
      interface_enable == $past(pwdata[CTRL_ENABLE_BIT]))
      else $error("enable bit not taken");
   a_start_sets: assert property (start_generated &&
      interface_enable && !stop_detected && !arbitration_lost && !ctl_wr
      |=> direction_flag) else $error("start did not set direction");
   a_slave_start: assert property (start_detected &&
      !start_generated |=> !direction_flag)
      else $error("start seen kept direction");
   a_ack_pin: assert property ($rose(ack_detected_flag) |->
      !$past(serial_data_pin_in, 3)) else $error("ack without low data");

   c_ack: cover property ($rose(ack_detected_flag));
   c_drive: cover property ($rose(serial_data_pin_oe));
   c_cancel: cover property (ctl_wr && pwdata[CTRL_WAIT_CANCEL_BIT] &&
      direction_flag);
endmodule
bind idas_status idas_status_props u_props (.sys_clk(sys_clk),
   .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .serial_data_pin_in(serial_data_pin_in),
   .serial_data_pin_out(serial_data_pin_out),
   .serial_data_pin_oe(serial_data_pin_oe),
   .shift_out_latch(shift_out_latch), .start_generated(start_generated),
   .start_detected(start_detected), .stop_detected(stop_detected),
   .arbitration_lost(arbitration_lost),
   .interface_enable(interface_enable), .direction_flag(direction_flag),
   .ack_detected_flag(ack_detected_flag));
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench of the direction and acknowledge status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb
   import idas_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready, pslverr, sda_out, sda_oe, ien, dir, ack, irq, scl, sda_low;
   logic latch = 1'b1;
   // Arbitration loss, stop, start seen, start issued
   logic [3:0] ev = 4'h0;
   // Pull-up: released line reads high
   wire sda = ~sda_low & ~(sda_oe & ~sda_out);
   int error_cnt = 0;
   int checks = 0;
   int seed = 41;
   int cyc = 0;
   logic [DATA_W:0] exp_q[$];

   idas_status u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_clock_pin(scl), .serial_data_pin_in(sda),
      .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe),
      .shift_out_latch(latch), .start_generated(ev[0]),
      .start_detected(ev[1]), .stop_detected(ev[2]),
      .arbitration_lost(ev[3]), .interface_enable(ien),
      .direction_flag(dir), .ack_detected_flag(ack), .irq(irq));
   idas_bus_peer u_peer (.scl(scl), .sda_low(sda_low));

   always #2.5 sys_clk = ~sys_clk;

   function automatic logic [DATA_W:0] s(input logic m, l, d, k);
      s = '0;
      s[STAT_MASTER_BIT] = m;
      s[STAT_ARB_LOSS_BIT] = l;
      s[STAT_DIR_BIT] = d;
      s[STAT_ACK_BIT] = k;
   endfunction

   task automatic close_out();
      $display("Comparisons %0d, errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [DATA_W:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, '0);
   endtask

   task automatic pulse(input logic [3:0] m);
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= 4'h0;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic byte_out(input logic [8:0] b);
      u_peer.clock_byte(b);
      repeat (8) @(posedge sys_clk);
   endtask

   // Read results are compared when the access phase completes
   always @(posedge sys_clk)
      if (psel && penable && pready && !pwrite)
         `CHK({pslverr, prdata}, exp_q.pop_front())

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      rd(STAT_OFF, s(0, 0, 0, 0));
      `CHK(sda_oe, 1'b0)
      apb(1'b1, CTRL_OFF, 32'h80);
      rd(CTRL_OFF, 33'h80);
      rd(8'h14, {1'b1, 32'h0});
      apb(1'b1, IRQ_EN_OFF, 32'h1);
      // Master write, acknowledged by the peer
      latch <= 1'($random(seed));
      pulse(4'h1);
      rd(STAT_OFF, s(1, 0, 1, 0));
      byte_out({7'($random(seed)), 2'b00});
      rd(STAT_OFF, s(1, 0, 1, 1));
      `CHK({ien, dir, ack}, 3'b111)
      `CHK(sda_oe, 1'b1)
      `CHK(sda_out, latch)
      rd(IRQ_STAT_OFF, 33'h3);
      `CHK(irq, 1'b1)
      apb(1'b1, IRQ_EN_OFF, 32'h0);
      repeat (3) @(posedge sys_clk);
      `CHK(irq, 1'b0)
      apb(1'b1, IRQ_EN_OFF, 32'h1);
      apb(1'b1, IRQ_CLR_OFF, 32'hf);
      repeat (3) @(posedge sys_clk);
      `CHK(irq, 1'b0)
      rd(IRQ_STAT_OFF, 33'h0);
      // Refused ack: next first clock clears the flag
      byte_out(9'h1ff);
      rd(STAT_OFF, s(1, 0, 1, 0));
      u_peer.release_bus();
      pulse(4'h4);
      rd(STAT_OFF, s(0, 0, 0, 0));
      `CHK(sda_oe, 1'b0)
      // Master read: the block sends a 1 as direction bit
      latch <= 1'b1;
      pulse(4'h1);
      byte_out({7'($random(seed)), 2'b11});
      rd(STAT_OFF, s(1, 0, 0, 0));
      `CHK(sda_oe, 1'b0)
      pulse(4'h1);
      pulse(4'h8);
      rd(STAT_OFF, s(0, 1, 0, 0));
      rd(STAT_OFF, s(0, 0, 0, 0));
      u_peer.release_bus();
      pulse(4'h4);
      // Slave: read, write, read; start seen clears direction
      for (int i = 0; i < 3; i++) begin
         pulse(4'h2);
         rd(STAT_OFF, s(0, 0, 0, 0));
         latch <= 1'($random(seed));
         byte_out({7'($random(seed)), ~i[0], 1'b1});
         rd(STAT_OFF, s(0, 0, ~i[0], 0));
         `CHK(sda_oe, ~i[0])
      end
      // Wait cancel at the ninth clock while transmitting
      apb(1'b1, CTRL_OFF, 32'ha0);
      rd(STAT_OFF, s(0, 0, 0, 0));
      `CHK(sda_oe, 1'b0)
      u_peer.release_bus();
      pulse(4'h4);
      // Exit request, then disable, each while transmitting
      for (int i = 0; i < 2; i++) begin
         pulse(4'h1);
         rd(STAT_OFF, s(1, 0, 1, 0));
         apb(1'b1, CTRL_OFF, i == 0 ? 32'hc0 : 32'h00);
         repeat (2) @(posedge sys_clk);
         rd(STAT_OFF, s(0, 0, 0, 0));
         `CHK({ien, dir, ack}, {i == 0, 2'b00})
      end
      close_out();
   end
endmodule
`default_nettype wire

// ===== include/idas_pkg.sv
// Constants, register map and types of the direction/acknowledge status block
//
// Contract
// - Direction flag 0 releases data pin
// - Direction flag 1 drives latch, after ninth fall; a master drives from its start condition
// - Stop, exit, disable, wait cancel, arbitration loss clear direction; the code clears it on a loss only while the loss flag is still clear
// - Master sending read bit clears direction
// - Master start or write bit sets direction
// - Slave start/write bit clears, read bit sets
// - Wait cancel at ninth clock releases pin
// - Data low at ninth rise sets acknowledge
// - Stop, next first clock, exit, disable clear acknowledge
// - Exit bit 6, enable bit 7 of control
// - Arbitration loss sets flag, clears master status
package idas_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register byte offsets on the APB side
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
   localparam logic [7:0] IRQ_CLR_OFF = 8'h0c;
   localparam logic [7:0] IRQ_EN_OFF = 8'h10;

   // Interface control register fields
   localparam int unsigned CTRL_ENABLE_BIT = 7;
   localparam int unsigned CTRL_EXIT_BIT = 6;
   localparam int unsigned CTRL_WAIT_CANCEL_BIT = 5;

   // Bus status flag fields
   localparam int unsigned STAT_MASTER_BIT = 7;
   localparam int unsigned STAT_ARB_LOSS_BIT = 6;
   localparam int unsigned STAT_DIR_BIT = 3;
   localparam int unsigned STAT_ACK_BIT = 2;

   // Interrupt event bits
   localparam int unsigned EV_W = 4;
   localparam int unsigned EV_ACK = 0;
   localparam int unsigned EV_NINTH = 1;
   localparam int unsigned EV_ARB_LOSS = 2;
   localparam int unsigned EV_STOP = 3;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [EV_W-1:0] IRQ_RESET = 4'h0;

   // Serial clock counts within a byte
   localparam logic [3:0] CNT_RESET = 4'h0;
   localparam logic [3:0] DIR_BIT_CLK = 4'h8;
   localparam logic [3:0] ACK_CLK = 4'h9;
   localparam logic [3:0] FIRST_CLK = 4'h1;

   typedef enum logic [1:0] {
      IDAS_IDLE = 2'b00,
      IDAS_FIRST = 2'b01,
      IDAS_DATA = 2'b10
   } idas_phase_e;

endpackage

// ===== verilog/idas_bit_counter.sv
// Serial clock counter: byte phase, ninth clock and direction bit strobes
`timescale 1ns/1ps
`default_nettype none
module idas_bit_counter
   import idas_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic start_event,
   input wire logic stop_event,
   input wire logic scl_rise,
   input wire logic scl_fall,
   output logic dir_bit_strobe,
   output logic ninth_rise,
   output logic ninth_fall,
   output logic first_clk_rise,
   output logic ack_slot
);
   idas_phase_e phase;
   idas_phase_e next_phase;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic next_ack_slot;

   wire in_byte = (phase != IDAS_IDLE);
   wire cnt_at_ack = (cnt == ACK_CLK);

   assign dir_bit_strobe = scl_rise && (phase == IDAS_FIRST) &&
      (cnt == DIR_BIT_CLK - 4'h1);
   assign ninth_rise = scl_rise && in_byte && (cnt == DIR_BIT_CLK);
   assign ninth_fall = scl_fall && in_byte && cnt_at_ack;
   assign first_clk_rise = scl_rise && in_byte && cnt_at_ack;

   always_comb begin
      next_phase = phase;
      next_cnt = cnt;
      next_ack_slot = ack_slot;
      if (!enable || stop_event) begin
         next_phase = IDAS_IDLE;
         next_cnt = CNT_RESET;
         next_ack_slot = 1'b0;
      end else if (start_event) begin
         next_phase = IDAS_FIRST;
         next_cnt = CNT_RESET;
         next_ack_slot = 1'b0;
      end else begin
         case (phase)
            IDAS_IDLE: begin
               next_cnt = CNT_RESET;
            end
            IDAS_FIRST, IDAS_DATA: begin
               if (first_clk_rise) begin
                  next_cnt = FIRST_CLK;
                  next_phase = IDAS_DATA;
               end else if (scl_rise) begin
                  next_cnt = cnt + 4'h1;
               end
               // Acknowledge slot spans eighth fall to ninth fall
               if (scl_fall && cnt == DIR_BIT_CLK) begin
                  next_ack_slot = 1'b1;
               end else if (ninth_fall) begin
                  next_ack_slot = 1'b0;
               end
            end
            default: begin
               next_phase = IDAS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         phase <= IDAS_IDLE;
         cnt <= CNT_RESET;
         ack_slot <= 1'b0;
      end else begin
         phase <= next_phase;
         cnt <= next_cnt;
         ack_slot <= next_ack_slot;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/idas_status.sv
// Direction and acknowledge status logic with APB registers and interrupt
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module idas_status
   import idas_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial bus pins
   input wire logic serial_clock_pin,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe,
   // Neighbouring interface logic, same clock
   input wire logic shift_out_latch,
   input wire logic start_generated,
   input wire logic start_detected,
   input wire logic stop_detected,
   input wire logic arbitration_lost,
   // Status mirrors and interrupt
   output logic interface_enable,
   output logic direction_flag,
   output logic ack_detected_flag,
   output logic irq
);
   // Control and flag state
   logic enable_q;
   logic master_comm_status;
   logic arbitration_loss_flag;
   logic drive_ok;
   logic [EV_W-1:0] irq_status;
   logic [EV_W-1:0] irq_enable;

   // Synchronised pins
   logic scl_level;
   logic scl_rise;
   logic scl_fall;
   logic sda_level;
   logic sda_rise;
   logic sda_fall;

   // Byte position strobes
   logic dir_bit_strobe;
   logic ninth_rise;
   logic ninth_fall;
   logic first_clk_rise;
   logic ack_slot;

   // Next values
   logic next_direction_flag;
   logic next_ack_detected_flag;
   logic next_master_comm_status;
   logic next_arbitration_loss_flag;
   logic next_drive_ok;
   logic [DATA_W-1:0] next_prdata;

   idas_sync_edge u_scl_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin(serial_clock_pin),
      .level(scl_level),
      .rise(scl_rise),
      .fall(scl_fall)
   );

   idas_sync_edge u_sda_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin(serial_data_pin_in),
      .level(sda_level),
      .rise(sda_rise),
      .fall(sda_fall)
   );

   idas_bit_counter u_bits (
      .sys_clk(sys_clk),
      .reset(reset),
      .enable(enable_q),
      .start_event(start_detected | start_generated),
      .stop_event(stop_detected),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .dir_bit_strobe(dir_bit_strobe),
      .ninth_rise(ninth_rise),
      .ninth_fall(ninth_fall),
      .first_clk_rise(first_clk_rise),
      .ack_slot(ack_slot)
   );

   // APB decode
   wire setup_phase = psel & ~penable;
   wire access_done = psel & penable & pready;
   wire wr_done = access_done & pwrite;
   wire rd_done = access_done & ~pwrite;
   wire sel_ctrl = (paddr == CTRL_OFF);
   wire sel_stat = (paddr == STAT_OFF);
   wire sel_irq_stat = (paddr == IRQ_STAT_OFF);
   wire sel_irq_clr = (paddr == IRQ_CLR_OFF);
   wire sel_irq_en = (paddr == IRQ_EN_OFF);
   wire addr_hit = sel_ctrl | sel_stat | sel_irq_stat | sel_irq_clr |
      sel_irq_en;

   // Control register writes; exit and wait cancel are one-shot commands
   wire ctrl_wr = wr_done & sel_ctrl;
   wire exit_comm_request = ctrl_wr & pwdata[CTRL_EXIT_BIT];
   wire wait_cancel = ctrl_wr & pwdata[CTRL_WAIT_CANCEL_BIT];
   wire next_enable = ctrl_wr ? pwdata[CTRL_ENABLE_BIT] : enable_q;
   wire enable_fall = enable_q & ~next_enable;
   wire status_read = rd_done & sel_stat;
   // Taken from the flag's next value so direction drops with the flag,
   // not one cycle after it
   wire arb_loss_rise = next_arbitration_loss_flag & ~arbitration_loss_flag;

   // Events that end communication for every role
   wire common_clear = stop_detected | exit_comm_request | enable_fall |
      ~enable_q;

   // Direction flag
   always_comb begin
      next_direction_flag = direction_flag;
      if (common_clear || wait_cancel || arb_loss_rise) begin
         next_direction_flag = 1'b0;
      end else if (master_comm_status || start_generated) begin
         if (start_generated) begin
            next_direction_flag = 1'b1;
         end else if (dir_bit_strobe) begin
            // Read bit on the wire turns the master into a receiver
            next_direction_flag = ~sda_level;
         end
      end else begin
         if (start_detected) begin
            next_direction_flag = 1'b0;
         end else if (dir_bit_strobe) begin
            next_direction_flag = sda_level;
         end
      end
   end

   // Slave transmit waits for the ninth falling edge so the ack is not
   // overdriven; a master owns the line from its own start condition
   always_comb begin
      next_drive_ok = drive_ok;
      if (!next_direction_flag) begin
         next_drive_ok = 1'b0;
      end else if (start_generated || ninth_fall) begin
         next_drive_ok = 1'b1;
      end
   end

   // Acknowledge detection
   always_comb begin
      next_ack_detected_flag = ack_detected_flag;
      if (common_clear || first_clk_rise) begin
         next_ack_detected_flag = 1'b0;
      end else if (ninth_rise && !sda_level) begin
         next_ack_detected_flag = 1'b1;
      end
   end

   // Master status and arbitration loss
   always_comb begin
      next_master_comm_status = master_comm_status;
      if (common_clear || arbitration_lost) begin
         next_master_comm_status = 1'b0;
      end else if (start_generated) begin
         next_master_comm_status = 1'b1;
      end
   end

   // A loss that arrives with the status read is kept, not lost
   always_comb begin
      next_arbitration_loss_flag = arbitration_loss_flag;
      if (arbitration_lost && enable_q) begin
         next_arbitration_loss_flag = 1'b1;
      end else if (status_read || enable_fall || !enable_q) begin
         next_arbitration_loss_flag = 1'b0;
      end
   end

   // Interrupt events
   logic [EV_W-1:0] ev_set;
   assign ev_set[EV_ACK] = ninth_rise & ~sda_level & enable_q;
   assign ev_set[EV_NINTH] = ninth_fall;
   assign ev_set[EV_ARB_LOSS] = arbitration_lost & enable_q;
   assign ev_set[EV_STOP] = stop_detected & enable_q;
   wire [EV_W-1:0] ev_clr = (wr_done & sel_irq_clr) ?
      pwdata[EV_W-1:0] : IRQ_RESET;
   wire [EV_W-1:0] next_irq_status = ev_set | (irq_status & ~ev_clr);
   wire [EV_W-1:0] next_irq_enable = (wr_done & sel_irq_en) ?
      pwdata[EV_W-1:0] : irq_enable;

   // Read data, captured in the setup cycle
   wire [7:0] stat_byte = {master_comm_status, arbitration_loss_flag, 2'b00,
      direction_flag, ack_detected_flag, 2'b00};
   wire [7:0] ctrl_byte = {enable_q, 7'h00};
   always_comb begin
      next_prdata = '0;
      if (sel_ctrl) begin
         next_prdata = {24'h000000, ctrl_byte};
      end else if (sel_stat) begin
         next_prdata = {24'h000000, stat_byte};
      end else if (sel_irq_stat) begin
         next_prdata = {{(DATA_W-EV_W){1'b0}}, irq_status};
      end else if (sel_irq_en) begin
         next_prdata = {{(DATA_W-EV_W){1'b0}}, irq_enable};
      end
   end

   // Bus handshake: no wait state, answer in the first access cycle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~addr_hit;
         prdata <= setup_phase ? next_prdata : prdata;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         enable_q <= CTRL_RESET[CTRL_ENABLE_BIT];
         direction_flag <= 1'b0;
         ack_detected_flag <= 1'b0;
         master_comm_status <= 1'b0;
         arbitration_loss_flag <= 1'b0;
         drive_ok <= 1'b0;
      end else begin
         enable_q <= next_enable;
         direction_flag <= next_direction_flag;
         ack_detected_flag <= next_ack_detected_flag;
         master_comm_status <= next_master_comm_status;
         arbitration_loss_flag <= next_arbitration_loss_flag;
         drive_ok <= next_drive_ok;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irq_status <= IRQ_RESET;
         irq_enable <= IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_enable <= next_irq_enable;
         irq <= |(next_irq_status & next_irq_enable);
      end
   end

   // Pin driver: released outside transmit and during the ack slot
   wire drive_now = next_drive_ok & next_direction_flag & ~ack_slot;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         serial_data_pin_out <= 1'b1;
         serial_data_pin_oe <= 1'b0;
         interface_enable <= 1'b0;
      end else begin
         serial_data_pin_out <= shift_out_latch;
         serial_data_pin_oe <= drive_now;
         interface_enable <= next_enable;
      end
   end

   // Level of the clock pin and data edges stay unused here
   wire unused_ok = &{1'b0, scl_level, sda_rise, sda_fall};
endmodule
`default_nettype wire

// ===== verilog/idas_sync_edge.sv
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/1ps
`default_nettype none
module idas_sync_edge
   import idas_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic sync;
   logic prev;

   // Pins idle high on this bus, so reset to 1 to avoid a false edge
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         meta <= 1'b1;
         sync <= 1'b1;
         prev <= 1'b1;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level = sync;
   assign rise = sync & ~prev;
   assign fall = ~sync & prev;
endmodule
`default_nettype wire
